// ---- scpsr_params.svh ----
// Constants for the serial configuration port with strap-loaded defaults
`ifndef SCPSR_PARAMS_SVH
`define SCPSR_PARAMS_SVH
`define SCPSR_ADDR_W 7
`define SCPSR_DATA_W 8
`define SCPSR_FRAME_BITS 16
`define SCPSR_CNT_W 5
`define SCPSR_ADDR_MSB_BIT 5'h0_001
`define SCPSR_ADDR_DONE_BIT 5'h0_008
`define SCPSR_FRAME_DONE 5'h0_010
`define SCPSR_NREGS 4
`define SCPSR_IDX_W 2
`define SCPSR_ADDR_INPUT_MODE 7'h0_034
`define SCPSR_ADDR_FREQ_A 7'h0_038
`define SCPSR_ADDR_FREQ_B 7'h0_064
`define SCPSR_ADDR_SPARE 7'h0_07E
`define SCPSR_BIT_NET_TYPE 2
`define SCPSR_BIT_FREQ_A_LO 5
`define SCPSR_BIT_FREQ_A_HI 6
`define SCPSR_BIT_FREQ_B 4
`define SCPSR_REG_RESET 8'h00_00
`endif

// ---- scpsr_pkg.sv ----
// Types shared by the serial configuration port
package scpsr_pkg;
  typedef enum logic [1:0] {
    SCPSR_IDLE = 2'b00,
    SCPSR_ADDR = 2'b01,
    SCPSR_DATA = 2'b10
  } scpsr_phase_t;
endpackage

// ---- scpsr_sync.sv ----
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module scpsr_sync #(
  parameter logic INIT_VAL = 1'b0 // Level held under reset
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic async_in, // Level from another domain
  output logic sync_out // Level safe to use
);
  logic meta_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= INIT_VAL;
      sync_out <= INIT_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ---- scpsr_port.sv ----
// Serial configuration port with strap-loaded SONET/SDH defaults
// Contract
// - Select low opens an access; the port only responds while select is low.
// - Edge select high makes the falling shift clock edge the active edge.
// - Default edge setting captures serial input on the rising clock edge.
// - Read data leaves serially on the dedicated serial output pin.
// - Master reset low returns the frame state and all registers to defaults; serial_out holds its value.
// - Strap level loads reg 34 bit 2, reg 38 bits 5,6, reg 64 bit 4.
// - Strap low selects SDH-rate defaults, strap high selects SONET-rate defaults.
// - Strap-derived bits stay writable by the host afterwards.
// - Each register is eight bits wide with a two-digit hex address.
// - Reg 34 bit 2 reads 1 for SONET, 0 for SDH; resets from strap.
// Frame: R/W bit (1 = read), 7 address bits MSB first, 8 data bits MSB first.
`timescale 1ns/1ps
`include "scpsr_params.svh"
module scpsr_port
  import scpsr_pkg::*;
(
  input wire logic clock, // 20 MHz system clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic master_reset_n, // Pin reset, active low
  input wire logic network_type_strap, // Strap: 1 SONET, 0 SDH
  input wire logic device_select_n, // Serial select, active low
  input wire logic serial_clock, // Serial shift clock
  input wire logic sample_edge_select, // 1 selects falling active edge
  input wire logic serial_in, // Serial data in
  output logic serial_out, // Serial data out
  output logic serial_out_oe_n, // Output enable, low while driving
  output logic network_type_bit, // Reg 34 bit 2 state
  output logic [`SCPSR_DATA_W-1:0] freq_sel_a, // Reg 38 contents
  output logic [`SCPSR_DATA_W-1:0] freq_sel_b // Reg 64 contents
);
  logic sel_n_s, sclk_s, din_s, edge_s, mrst_n_s, strap_s;
  logic sclk_d_r, mrst_n_d_r, load_strap_r;
  logic [`SCPSR_CNT_W-1:0] bit_cnt_r;
  logic rd_r;
  logic [`SCPSR_ADDR_W-1:0] addr_r;
  logic [`SCPSR_DATA_W-1:0] shift_r;
  logic [`SCPSR_DATA_W-1:0] regs_r [`SCPSR_NREGS];
  scpsr_phase_t phase_r;
  logic active_edge, shift_edge, rise, fall, hit;
  logic [`SCPSR_IDX_W-1:0] idx;

  // Select idles high so a fresh reset never looks like an open access
  scpsr_sync #(.INIT_VAL(1'b1)) u_sel (.clock(clock), .sys_rst(sys_rst),
    .async_in(device_select_n), .sync_out(sel_n_s));
  scpsr_sync u_sclk (.clock(clock), .sys_rst(sys_rst),
    .async_in(serial_clock), .sync_out(sclk_s));
  scpsr_sync u_din (.clock(clock), .sys_rst(sys_rst),
    .async_in(serial_in), .sync_out(din_s));
  scpsr_sync u_edge (.clock(clock), .sys_rst(sys_rst),
    .async_in(sample_edge_select), .sync_out(edge_s));
  // Master reset reads as asserted until the pin has been seen high
  scpsr_sync u_mrst (.clock(clock), .sys_rst(sys_rst),
    .async_in(master_reset_n), .sync_out(mrst_n_s));
  scpsr_sync u_strap (.clock(clock), .sys_rst(sys_rst),
    .async_in(network_type_strap), .sync_out(strap_s));

  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;
  assign active_edge = edge_s ? fall : rise;
  assign shift_edge = edge_s ? rise : fall;

  always_comb begin
    hit = 1'b1;
    idx = '0;
    unique case (addr_r)
      `SCPSR_ADDR_INPUT_MODE: idx = 2'd0;
      `SCPSR_ADDR_FREQ_A: idx = 2'd1;
      `SCPSR_ADDR_FREQ_B: idx = 2'd2;
      `SCPSR_ADDR_SPARE: idx = 2'd3;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_r <= 1'b0;
      mrst_n_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      mrst_n_d_r <= mrst_n_s;
    end
  end

  // Strap caught by a clocked load after either reset releases
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      load_strap_r <= 1'b1;
    end else begin
      load_strap_r <= ~mrst_n_s | (mrst_n_s & ~mrst_n_d_r);
    end
  end

  // Serial framing; pin reset or select high abandons the frame
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r <= SCPSR_IDLE;
      bit_cnt_r <= '0;
      rd_r <= 1'b0;
      addr_r <= '0;
      shift_r <= '0;
    end else if (!mrst_n_s || sel_n_s) begin
      // Direction and address dropped too, so a cut frame leaves nothing behind
      phase_r <= SCPSR_IDLE;
      bit_cnt_r <= '0;
      rd_r <= 1'b0;
      addr_r <= '0;
      shift_r <= '0;
    end else if (active_edge) begin
      bit_cnt_r <= bit_cnt_r + 5'd1;
      unique case (phase_r)
        SCPSR_IDLE: begin
          rd_r <= din_s;
          phase_r <= SCPSR_ADDR;
        end
        SCPSR_ADDR: begin
          addr_r <= {addr_r[`SCPSR_ADDR_W-2:0], din_s};
          if (bit_cnt_r == `SCPSR_ADDR_DONE_BIT - 5'd1) begin
            phase_r <= SCPSR_DATA;
          end
        end
        SCPSR_DATA: begin
          shift_r <= {shift_r[`SCPSR_DATA_W-2:0], din_s};
          if (bit_cnt_r == `SCPSR_FRAME_DONE - 5'd1) begin
            phase_r <= SCPSR_IDLE;
          end
        end
      endcase
    end else if (phase_r == SCPSR_DATA && rd_r && bit_cnt_r == `SCPSR_ADDR_DONE_BIT
                 && shift_edge) begin
      shift_r <= hit ? regs_r[idx] : `SCPSR_REG_RESET;
    end
  end

  // Register file; writes commit at the sixteenth bit
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `SCPSR_NREGS; i++) begin
        regs_r[i] <= `SCPSR_REG_RESET;
      end
    end else if (load_strap_r) begin
      for (int i = 0; i < `SCPSR_NREGS; i++) begin
        regs_r[i] <= `SCPSR_REG_RESET;
      end
      regs_r[0][`SCPSR_BIT_NET_TYPE] <= strap_s;
      regs_r[1][`SCPSR_BIT_FREQ_A_LO] <= strap_s;
      regs_r[1][`SCPSR_BIT_FREQ_A_HI] <= strap_s;
      regs_r[2][`SCPSR_BIT_FREQ_B] <= strap_s;
    end else if (!sel_n_s && active_edge && phase_r == SCPSR_DATA && !rd_r && hit
                 && bit_cnt_r == `SCPSR_FRAME_DONE - 5'd1) begin
      regs_r[idx] <= {shift_r[`SCPSR_DATA_W-2:0], din_s};
    end
  end

  // Output driven from flops, changed on the non-sampling edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out_oe_n <= ~(!sel_n_s && rd_r && phase_r == SCPSR_DATA);
      if (phase_r == SCPSR_DATA && rd_r && shift_edge) begin
        serial_out <= (bit_cnt_r == `SCPSR_ADDR_DONE_BIT)
                      ? (hit ? regs_r[idx][`SCPSR_DATA_W-1] : 1'b0)
                      : shift_r[`SCPSR_DATA_W-1];
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      network_type_bit <= 1'b0;
      freq_sel_a <= `SCPSR_REG_RESET;
      freq_sel_b <= `SCPSR_REG_RESET;
    end else begin
      network_type_bit <= regs_r[0][`SCPSR_BIT_NET_TYPE];
      freq_sel_a <= regs_r[1];
      freq_sel_b <= regs_r[2];
    end
  end

  a_strap_load: assert property (@(posedge clock) disable iff (sys_rst)
    load_strap_r |=> regs_r[0][`SCPSR_BIT_NET_TYPE] == $past(strap_s))
    else $error("strap not loaded into network type bit");
  a_strap_freq: assert property (@(posedge clock) disable iff (sys_rst)
    load_strap_r |=> regs_r[1][`SCPSR_BIT_FREQ_A_LO] == $past(strap_s)
      && regs_r[1][`SCPSR_BIT_FREQ_A_HI] == $past(strap_s)
      && regs_r[2][`SCPSR_BIT_FREQ_B] == $past(strap_s))
    else $error("strap not loaded into frequency bits");
  a_load_release: assert property (@(posedge clock) disable iff (sys_rst)
    (mrst_n_s && !mrst_n_d_r) |=> load_strap_r)
    else $error("strap not reloaded after master reset");
  a_idle_deselect: assert property (@(posedge clock) disable iff (sys_rst)
    sel_n_s |=> phase_r == SCPSR_IDLE && serial_out_oe_n)
    else $error("port active while deselected");
  a_oe_release: assert property (@(posedge clock) disable iff (sys_rst)
    (sel_n_s || !rd_r) |=> serial_out_oe_n)
    else $error("output enabled outside a read");
  a_reset_idle: assert property (@(posedge clock) disable iff (sys_rst)
    !mrst_n_s |=> phase_r == SCPSR_IDLE ##1 regs_r[3] == `SCPSR_REG_RESET)
    else $error("master reset did not clear state");
  a_net_out: assert property (@(posedge clock) disable iff (sys_rst)
    1'b1 |=> network_type_bit == $past(regs_r[0][`SCPSR_BIT_NET_TYPE]))
    else $error("network type output stale");
  a_rise_count: assert property (@(posedge clock) disable iff (sys_rst)
    (!sel_n_s && mrst_n_s && !edge_s && rise && !load_strap_r)
    |=> bit_cnt_r == $past(bit_cnt_r) + 5'd1 || phase_r == SCPSR_IDLE)
    else $error("rising edge not sampled");
  a_fall_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (edge_s && rise && !fall) |=> bit_cnt_r == $past(bit_cnt_r) || phase_r == SCPSR_IDLE)
    else $error("rising edge sampled in falling mode");
  a_write_commit: assert property (@(posedge clock) disable iff (sys_rst)
    (!sel_n_s && mrst_n_s && active_edge && phase_r == SCPSR_DATA && !rd_r && hit
     && !load_strap_r && bit_cnt_r == `SCPSR_FRAME_DONE - 5'd1)
    |=> regs_r[$past(idx)] == $past({shift_r[`SCPSR_DATA_W-2:0], din_s}))
    else $error("write not committed");
  a_read_drive: assert property (@(posedge clock) disable iff (sys_rst)
    (!sel_n_s && rd_r && phase_r == SCPSR_DATA) |=> !serial_out_oe_n)
    else $error("read data not driven");
  a_read_first: assert property (@(posedge clock) disable iff (sys_rst)
    (phase_r == SCPSR_DATA && rd_r && shift_edge && hit
     && bit_cnt_r == `SCPSR_ADDR_DONE_BIT)
    |=> serial_out == $past(regs_r[idx][`SCPSR_DATA_W-1]))
    else $error("first read bit is not the register top bit");
  a_out_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(phase_r == SCPSR_DATA && rd_r && shift_edge) |=> $stable(serial_out))
    else $error("serial output changed off the shift edge");
endmodule

// ---- scpsr_host_model.sv ----
// Serial master model standing in for the host processor
`timescale 1ns/1ps
module scpsr_host_model (
  input wire logic clock, // System clock
  input wire logic edge_sel, // 1 falling active edge
  input wire logic serial_out, // Read data from port
  output logic device_select_n, // Select, active low
  output logic serial_clock, // Shift clock
  output logic serial_in // Data to port
);
  initial begin
    device_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // Sends n bits of R/W, address, data; n below 16 aborts the frame
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] wd,
      input int n, output logic [7:0] rd);
    logic [15:0] f;
    f = {rw, addr, wd};
    rd = 8'h00;
    @(posedge clock);
    // Idle level set before select so no stray active edge is seen
    serial_clock <= edge_sel;
    repeat (4) @(posedge clock);
    device_select_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 15; i > 15 - n; i--) begin
      serial_in <= f[i];
      serial_clock <= edge_sel;
      repeat (4) @(posedge clock);
      serial_clock <= ~edge_sel;
      repeat (2) @(posedge clock);
      if (i < 8) rd[i] = serial_out;
      repeat (2) @(posedge clock);
    end
    serial_clock <= edge_sel;
    repeat (4) @(posedge clock);
    device_select_n <= 1'b1;
    serial_in <= ~serial_in;
    repeat (8) @(posedge clock);
  endtask
endmodule

// ---- tb_scpsr_port.sv ----
// Testbench for the serial configuration port
`timescale 1ns/1ps
module tb_scpsr_port;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic master_reset_n = 1'b1;
  logic strap = 1'b1;
  logic edge_sel = 1'b0;
  logic sel_n, sclk, ser_in, ser_out, ser_out_oe_n, ser_line, net_bit;
  logic [7:0] fa, fb, rd;
  int err_total = 0;
  int checks_done = 0;
  scpsr_port uut (.clock(clock), .sys_rst(sys_rst), .master_reset_n(master_reset_n),
    .network_type_strap(strap), .device_select_n(sel_n), .serial_clock(sclk),
    .sample_edge_select(edge_sel), .serial_in(ser_in), .serial_out(ser_out),
    .serial_out_oe_n(ser_out_oe_n), .network_type_bit(net_bit), .freq_sel_a(fa),
    .freq_sel_b(fb));
  // Released output falls to the pin's pull-down, so a missing enable shows up
  assign ser_line = ser_out_oe_n ? 1'b0 : ser_out;
  scpsr_host_model host (.clock(clock), .edge_sel(edge_sel), .serial_out(ser_line),
    .device_select_n(sel_n), .serial_clock(sclk), .serial_in(ser_in));
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    host.xfer(1'b1, a, 8'h00, 16, rd);
    chk("read data", exp, rd);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, 16, rd);
  endtask
  task automatic summarize;
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clock);
    chk("net bit", 8'h01, {7'h00, net_bit});
    chk("freq a", 8'h60, fa);
    chk("freq b", 8'h10, fb);
    chk("out enable", 8'h01, {7'h00, ser_out_oe_n});
    rd_chk(7'h34, 8'h04);
    rd_chk(7'h7E, 8'h00);
    $display("Test strap defaults done");
    wr(7'h34, 8'h00);
    chk("net bit", 8'h00, {7'h00, net_bit});
    wr(7'h64, 8'h5A);
    chk("freq b", 8'h5A, fb);
    edge_sel <= 1'b1;
    wr(7'h38, 8'hA5);
    chk("freq a", 8'hA5, fa);
    rd_chk(7'h38, 8'hA5);
    edge_sel <= 1'b0;
    $display("Test override done");
    // Unmapped place must drop the write and read back zero
    wr(7'h10, 8'hFF);
    rd_chk(7'h10, 8'h00);
    wr(7'h7E, 8'h3C);
    host.xfer(1'b0, 7'h7E, 8'hC3, 12, rd);
    rd_chk(7'h7E, 8'h3C);
    chk("out enable", 8'h01, {7'h00, ser_out_oe_n});
    $display("Test refusal done");
    strap <= 1'b0;
    master_reset_n <= 1'b0;
    repeat (10) @(posedge clock);
    chk("freq a", 8'h00, fa);
    master_reset_n <= 1'b1;
    repeat (10) @(posedge clock);
    rd_chk(7'h7E, 8'h00);
    rd_chk(7'h34, 8'h00);
    chk("freq b", 8'h00, fb);
    chk("net bit", 8'h00, {7'h00, net_bit});
    $display("Test master reset done");
    summarize();
  end
endmodule
